// [cse_pkg.sv]
// Purpose: shared constants and types for the checksum engine
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   all register offsets, field positions, and the page and count reset values live here
`default_nettype none
package cse_pkg;
    // register byte offsets on apb
    localparam logic [7:0]  CSE_OFF_CTRL    = 8'h00; // checksum control
    localparam logic [7:0]  CSE_OFF_BYTEIN  = 8'h04; // byte input
    localparam logic [7:0]  CSE_OFF_DATA    = 8'h08; // result data port
    localparam logic [7:0]  CSE_OFF_AUTO    = 8'h0C; // automatic control
    localparam logic [7:0]  CSE_OFF_CNT     = 8'h10; // block count
    localparam logic [7:0]  CSE_OFF_STAT    = 8'h14; // status
    // control register field positions
    localparam int          CSE_CTRL_INIT   = 0;     // init strobe
    localparam int          CSE_CTRL_VAL    = 1;     // seed select
    localparam int          CSE_CTRL_PNT    = 2;     // byte pointer
    localparam int          CSE_AUTO_EN     = 7;     // auto enable bit
    // polynomial and seeds
    localparam logic [15:0] CSE_POLY        = 16'h1021;
    localparam logic [15:0] CSE_SEED_ZERO   = 16'h0000;
    localparam logic [15:0] CSE_SEED_ONES   = 16'hFFFF;
    // reset values
    localparam logic [6:0]  CSE_RST_PAGE    = 7'h00;
    localparam logic [7:0]  CSE_RST_CNT     = 8'h00;
    localparam logic [7:0]  CSE_BLK_LAST    = 8'hFF; // last offset in block
    localparam int          CSE_FLASH_AW    = 15;    // page(7) + offset(8)
    // automatic walk states, gray along the usual path
    typedef enum logic [1:0]
    {
        CSE_IDLE  = 2'b00,
        CSE_REQ   = 2'b01,
        CSE_WAIT  = 2'b11,
        CSE_DRAIN = 2'b10
    } cse_state_t;
endpackage : cse_pkg
`default_nettype wire

// [cse_byte_if.sv]
// Purpose: byte stream carrier between buffer and crc datapath
// Assumes: valid/ready handshake, transfer on both high
// Notes:   src drives data and valid, snk drives ready
`default_nettype none
interface cse_byte_if;
    logic [7:0] data;
    logic       valid;
    logic       ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : cse_byte_if
`default_nettype wire

// [cse_buf2.sv]
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   full and empty are exact; a stalled drain fills it
`default_nettype none
module cse_buf2
    import cse_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    cse_byte_if.snk   in_if,
    cse_byte_if.src   out_if
);
    logic [7:0] mem_ff [2];
    logic       wr_ptr_ff;
    logic       rd_ptr_ff;
    logic [1:0] cnt_ff;
    logic       push;
    logic       pop;

    // handshake terms
    assign in_if.ready  = (cnt_ff != 2'd2);
    assign out_if.valid = (cnt_ff != 2'd0);
    assign out_if.data  = mem_ff[rd_ptr_ff];
    assign push = in_if.valid & in_if.ready;
    assign pop  = out_if.valid & out_if.ready;

    // storage, no reset needed on data
    always_ff @(posedge i_core_clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_if.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop)
            begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : cse_buf2
`default_nettype wire

// [cse_crc_step.sv]
// Purpose: combinational one-byte crc update
// Assumes: msb first, no reflection, no final inversion
// Notes:   eight shift steps are unrolled by a loop
`default_nettype none
module cse_crc_step
    import cse_pkg::*;
(
    input  wire logic [15:0] i_acc,
    input  wire logic [7:0]  i_byte,
    output logic      [15:0] o_acc
);
    // xor byte into upper half, then eight conditional shifts
    always_comb
    begin
        logic [15:0] t;
        t = i_acc ^ {i_byte, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            if (t[15])
            begin
                t = {t[14:0], 1'b0} ^ CSE_POLY;
            end
            else
            begin
                t = {t[14:0], 1'b0};
            end
        end
        o_acc = t;
    end
endmodule : cse_crc_step
`default_nettype wire

// [cse_top.sv]
// Purpose: 16-bit crc engine with byte feed and automatic flash walk
// Assumes: apb slave, flash read port answers with a valid pulse
// Notes:   processor is held on o_cpu_stall during automatic runs
// Operation
// - polynomial 0x1021, msb first, no reflection, no final invert.
// - xor byte into upper half, then eight conditional shift steps.
// - seed select zero gives 0x0000, one gives 0xFFFF.
// - writing one to init strobe loads the selected seed.
// - each byte written to byte input updates the accumulator.
// - automatic mode checksums consecutive 256-byte flash blocks.
// - with auto enabled any control write starts the flash walk; here only with a nonzero block count.
// - processor is stalled until all requested blocks are done.
// - accumulator is sixteen bits, reached byte-wise via data port.
// - byte pointer selects accessed byte, advances on every access.
// - accumulator holds until reseeded, overwritten or fed bytes.
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
module cse_top
    import cse_pkg::*;
(
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_b,
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [7:0]              i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    output logic      [CSE_FLASH_AW-1:0] o_flash_addr,
    output logic                         o_flash_req,
    input  wire logic [7:0]              i_flash_data,
    input  wire logic                    i_flash_valid,
    output logic                         o_cpu_stall
);
    cse_state_t  state_ff;
    logic [15:0] acc_ff;
    logic        val_sel_ff;
    logic        pnt_ff;
    logic [6:0]  page_ff;
    logic        auto_en_ff;
    logic [7:0]  cnt_ff;
    logic [7:0]  blk_left_ff;
    logic [CSE_FLASH_AW-1:0] addr_ff;
    logic        start_walk;
    logic        byte_taken;
    logic        walk_done;
    logic        busy_ff;
    logic [31:0] prdata_ff;
    logic        wr_acc;
    logic        rd_acc;
    logic        buf_in_ready;
    logic [15:0] nxt_acc;
    logic        last_issue;

    cse_byte_if  fill_if ();
    cse_byte_if  drain_if ();

    // register access decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // mapped words of the register map; anything else is refused
    function automatic logic mapped(input logic [7:0] a);
        if (a == CSE_OFF_CTRL)
        begin
            mapped = 1'b1;
        end
        else if (a == CSE_OFF_BYTEIN)
        begin
            mapped = 1'b1;
        end
        else if (a == CSE_OFF_DATA)
        begin
            mapped = 1'b1;
        end
        else if (a == CSE_OFF_AUTO)
        begin
            mapped = 1'b1;
        end
        else if (a == CSE_OFF_CNT)
        begin
            mapped = 1'b1;
        end
        else if (a == CSE_OFF_STAT)
        begin
            mapped = 1'b1;
        end
        else
        begin
            mapped = 1'b0;
        end
    endfunction : mapped

    // bus is held while busy so software never races the walk
    assign wr_acc    = i_psel & i_penable & i_pwrite & o_pready;
    assign rd_acc    = i_psel & i_penable & ~i_pwrite & o_pready;
    assign o_pready  = ~busy_ff;
    assign o_prdata  = prdata_ff;
    assign o_cpu_stall = busy_ff;

    // unmapped addresses answer with slverr
    assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);

    // byte source: flash while walking, software byte writes otherwise
    always_comb
    begin
        if (busy_ff)
        begin
            fill_if.valid = i_flash_valid;
            fill_if.data  = i_flash_data;
        end
        else
        begin
            fill_if.valid = wr_acc & hit(i_paddr, CSE_OFF_BYTEIN);
            fill_if.data  = i_pwdata[7:0];
        end
    end
    assign buf_in_ready = fill_if.ready;

    cse_buf2 u_buf
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .in_if      (fill_if),
        .out_if     (drain_if)
    );

    cse_crc_step u_step
    (
        .i_acc  (acc_ff),
        .i_byte (drain_if.data),
        .o_acc  (nxt_acc)
    );

    // datapath always takes a buffered byte
    assign drain_if.ready = 1'b1;

    // accumulator: seed, direct overwrite, or byte update
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            acc_ff <= CSE_SEED_ZERO;
        end
        else if (wr_acc & hit(i_paddr, CSE_OFF_CTRL)
                 & i_pwdata[CSE_CTRL_INIT])
        begin
            acc_ff <= i_pwdata[CSE_CTRL_VAL] ? CSE_SEED_ONES
                                             : CSE_SEED_ZERO;
        end
        else if (wr_acc & hit(i_paddr, CSE_OFF_DATA))
        begin
            if (pnt_ff)
            begin
                acc_ff[15:8] <= i_pwdata[7:0];
            end
            else
            begin
                acc_ff[7:0] <= i_pwdata[7:0];
            end
        end
        else if (drain_if.valid)
        begin
            acc_ff <= nxt_acc;
        end
    end

    // control fields: seed select and byte pointer
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            val_sel_ff <= 1'b0;
            pnt_ff     <= 1'b0;
        end
        else if (wr_acc & hit(i_paddr, CSE_OFF_CTRL))
        begin
            val_sel_ff <= i_pwdata[CSE_CTRL_VAL];
            pnt_ff     <= i_pwdata[CSE_CTRL_PNT];
        end
        else if ((wr_acc | rd_acc) & hit(i_paddr, CSE_OFF_DATA))
        begin
            pnt_ff <= ~pnt_ff;
        end
    end

    // automatic control and block count
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            page_ff    <= CSE_RST_PAGE;
            auto_en_ff <= 1'b0;
            cnt_ff     <= CSE_RST_CNT;
        end
        else if (wr_acc & hit(i_paddr, CSE_OFF_AUTO))
        begin
            page_ff    <= i_pwdata[6:0];
            auto_en_ff <= i_pwdata[CSE_AUTO_EN];
        end
        else if (wr_acc & hit(i_paddr, CSE_OFF_CNT))
        begin
            cnt_ff <= i_pwdata[7:0];
        end
    end

    // read data captured at the end of the setup phase
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            prdata_ff <= 32'h0000_0000;
        end
        else if (i_psel & ~i_penable & ~i_pwrite)
        begin
            if (hit(i_paddr, CSE_OFF_CTRL))
            begin
                prdata_ff <= {29'h0, pnt_ff, val_sel_ff, 1'b0};
            end
            else if (hit(i_paddr, CSE_OFF_DATA))
            begin
                prdata_ff <= {24'h0, pnt_ff ? acc_ff[15:8] : acc_ff[7:0]};
            end
            else if (hit(i_paddr, CSE_OFF_AUTO))
            begin
                prdata_ff <= {24'h0, auto_en_ff, page_ff};
            end
            else if (hit(i_paddr, CSE_OFF_CNT))
            begin
                prdata_ff <= {24'h0, cnt_ff};
            end
            else if (hit(i_paddr, CSE_OFF_STAT))
            begin
                prdata_ff <= {31'h0, busy_ff};
            end
            else
            begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // last fetch of the last block
    assign last_issue = (addr_ff[7:0] == CSE_BLK_LAST)
                        & (blk_left_ff == 8'd1);
    assign o_flash_addr = addr_ff;
    assign o_flash_req  = (state_ff == CSE_REQ);

    // a control write starts a walk only when enabled with blocks to do
    assign start_walk = (state_ff == CSE_IDLE) & wr_acc
                        & hit(i_paddr, CSE_OFF_CTRL) & auto_en_ff
                        & (cnt_ff != 8'h00);
    // a flash byte counts only once the buffer has room for it
    assign byte_taken = (state_ff == CSE_WAIT) & i_flash_valid
                        & buf_in_ready;
    // stall holds until the buffer has handed on every byte
    assign walk_done  = (state_ff == CSE_DRAIN) & ~drain_if.valid;

    // walk sequencing: one request, wait for its byte, repeat
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            state_ff <= CSE_IDLE;
        end
        else
        begin
            case (state_ff)
                CSE_IDLE:
                begin
                    if (start_walk)
                    begin
                        state_ff <= CSE_REQ;
                    end
                end
                CSE_REQ:
                begin
                    state_ff <= CSE_WAIT;
                end
                CSE_WAIT:
                begin
                    if (byte_taken)
                    begin
                        if (last_issue)
                        begin
                            state_ff <= CSE_DRAIN;
                        end
                        else
                        begin
                            state_ff <= CSE_REQ;
                        end
                    end
                end
                CSE_DRAIN:
                begin
                    if (walk_done)
                    begin
                        state_ff <= CSE_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= CSE_IDLE;
                end
            endcase
        end
    end

    // processor stall: set by the start, dropped after the last byte lands
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            busy_ff <= 1'b0;
        end
        else if (start_walk)
        begin
            busy_ff <= 1'b1;
        end
        else if (walk_done)
        begin
            busy_ff <= 1'b0;
        end
    end

    // fetch address and blocks still to go
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            addr_ff     <= '0;
            blk_left_ff <= 8'h00;
        end
        else if (start_walk)
        begin
            addr_ff     <= {page_ff, 8'h00};
            blk_left_ff <= cnt_ff;
        end
        else if (byte_taken & ~last_issue)
        begin
            // the count drops as the last offset of a block is passed
            if (addr_ff[7:0] == CSE_BLK_LAST)
            begin
                blk_left_ff <= blk_left_ff - 8'd1;
            end
            addr_ff <= addr_ff + 1'b1;
        end
    end
endmodule : cse_top
`default_nettype wire

// [cse_top_monitor.sv]
// Purpose: port-level checks for the checksum engine
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the ports of cse_top
`default_nettype none
module cse_mon
    import cse_pkg::*;
(
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_b,
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [7:0]              i_paddr,
    input  wire logic [31:0]             i_pwdata,
    input  wire logic [31:0]             o_prdata,
    input  wire logic                    o_pready,
    input  wire logic                    o_pslverr,
    input  wire logic [CSE_FLASH_AW-1:0] o_flash_addr,
    input  wire logic                    o_flash_req,
    input  wire logic [7:0]              i_flash_data,
    input  wire logic                    i_flash_valid,
    input  wire logic                    o_cpu_stall
);
    logic [CSE_FLASH_AW-1:0] last_addr_ff;
    logic                    seen_req_ff;
    logic                    bad_addr;
    // offsets past status or off a word boundary are unmapped
    assign bad_addr = (i_paddr > CSE_OFF_STAT) || (i_paddr[1:0] != 2'b00);
    // remember the previous fetch within one run; cleared between runs
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b || !o_cpu_stall)
            seen_req_ff <= 1'b0;
        else if (o_flash_req)
            seen_req_ff <= 1'b1;
    end
    always_ff @(posedge i_core_clk)
    begin
        if (o_flash_req)
            last_addr_ff <= o_flash_addr;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // steps of one automatic run
    sequence s_run_start;
        $rose(o_cpu_stall);
    endsequence
    sequence s_fetch;
        o_flash_req;
    endsequence
    // reset view is checked with reset itself as the cause
    AST_RST_VALS: assert property (disable iff (1'b0) !i_rst_b |=>
        o_pready && !o_cpu_stall && !o_flash_req && o_prdata == 32'h0)
        else $error("outputs not at reset values");
    AST_REQ_PULSE: assert property (s_fetch |=> !o_flash_req)
        else $error("fetch request longer than one cycle");
    AST_ADDR_STEP: assert property (s_fetch and seen_req_ff |->
        o_flash_addr == last_addr_ff + 1'b1)
        else $error("fetch address not ascending by one");
    AST_START_REQ: assert property (s_run_start |-> ##[0:2] s_fetch)
        else $error("run started without a fetch");
    AST_STALL_CAUSE: assert property (s_run_start |->
        $past(i_psel && i_penable && i_pwrite && o_pready
              && i_paddr == CSE_OFF_CTRL))
        else $error("stall rose without a control write");
    AST_STALL_END: assert property ($fell(o_cpu_stall) |->
        $past(i_flash_valid, 1) || $past(i_flash_valid, 2)
        || $past(i_flash_valid, 3) || $past(i_flash_valid, 4))
        else $error("stall fell without a final flash byte");
    AST_REQ_STALL: assert property (s_fetch |-> o_cpu_stall)
        else $error("fetch outside a stalled run");
    AST_REQ_HOLD: assert property (s_fetch |-> !o_pready)
        else $error("bus answered while fetching");
    AST_SLVERR: assert property (i_psel && i_penable |->
        o_pslverr == bad_addr)
        else $error("error response does not match address map");
endmodule : cse_mon
bind cse_top cse_mon u_mon (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_flash_addr(o_flash_addr), .o_flash_req(o_flash_req),
    .i_flash_data(i_flash_data), .i_flash_valid(i_flash_valid),
    .o_cpu_stall(o_cpu_stall));
`default_nettype wire

// [cse_tb.sv]
// Purpose: self-checking bench for the checksum engine
// Assumes: apb master drives by non-blocking assignment after edges
// Notes:   flash is answered here, two cycles after each request
`default_nettype none
module tb
    import cse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PG = 5;
    logic                    i_core_clk, i_rst_b, i_psel, i_penable;
    logic                    i_pwrite, i_flash_valid, o_pready, o_pslverr;
    logic                    o_flash_req, o_cpu_stall, req_d, perr;
    logic [7:0]              i_paddr, i_flash_data;
    logic [31:0]             i_pwdata, o_prdata, rdata;
    logic [CSE_FLASH_AW-1:0] o_flash_addr, addr_d, exp_fa;
    int                      err_count, n_checks, n_req, cyc;
    logic [7:0]              bs [5] = '{8'h00, 8'h00, 8'hAA, 8'hBB, 8'hCC};
    cse_top dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_flash_addr(o_flash_addr), .o_flash_req(o_flash_req),
        .i_flash_data(i_flash_data), .i_flash_valid(i_flash_valid),
        .o_cpu_stall(o_cpu_stall));
    always #10 i_core_clk = ~i_core_clk;
    // flash content: a fixed scramble of the address
    function automatic logic [7:0] fdat(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3C;
    endfunction : fdat
    // reference byte update, msb first
    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
            c = c[15] ? ((c << 1) ^ CSE_POLY) : (c << 1);
        return c;
    endfunction : crc_upd
    // flash answers late; idle data toggles so stale bytes never match
    always @(posedge i_core_clk)
    begin
        cyc <= cyc + 1;
        req_d <= o_flash_req;
        addr_d <= o_flash_addr;
        i_flash_valid <= req_d;
        i_flash_data <= req_d ? fdat(addr_d) : ~i_flash_data;
        if (o_flash_req === 1'b1)
        begin
            chk(32'(o_flash_addr), 32'(exp_fa));
            exp_fa <= exp_fa + 1'b1;
            n_req <= n_req + 1;
        end
        if (cyc == 10000)
        begin
            err_count++;
            $display("MISMATCH t=%0t bench ran out of time", $time);
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits on pready, the global timeout cuts a hang
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_core_clk);
        while (o_pready !== 1'b1);
        rdata = o_prdata;
        perr  = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_core_clk);
    endtask : apb
    // pointer back to the low byte, then read both bytes
    task automatic rd_res(input logic [15:0] e);
        apb(1'b1, CSE_OFF_CTRL, 32'h0);
        apb(1'b0, CSE_OFF_DATA, 32'h0);
        chk(32'(rdata[7:0]), 32'(e[7:0]));
        apb(1'b0, CSE_OFF_DATA, 32'h0);
        chk(32'(rdata[7:0]), 32'(e[15:8]));
    endtask : rd_res
    task automatic t_bytes;
        logic [15:0] e;
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, CSE_OFF_CTRL, 32'(s * 2 + 1));
            e = s ? CSE_SEED_ONES : CSE_SEED_ZERO;
            rd_res(e);
            foreach (bs[i])
            begin
                apb(1'b1, CSE_OFF_BYTEIN, {24'h0, bs[i]});
                e = crc_upd(e, bs[i]);
            end
            rd_res(e);
            apb(1'b0, CSE_OFF_DATA, 32'h0);
            chk(32'(rdata[7:0]), 32'(e[7:0]));
        end
    endtask : t_bytes
    task automatic t_over;
        apb(1'b1, CSE_OFF_CTRL, 32'h0);
        apb(1'b1, CSE_OFF_DATA, 32'h12);
        apb(1'b1, CSE_OFF_DATA, 32'h34);
        rd_res(16'h3412);
        apb(1'b1, CSE_OFF_CTRL, 32'h4);
        apb(1'b0, CSE_OFF_DATA, 32'h0);
        chk(32'(rdata[7:0]), 32'h34);
        apb(1'b1, 8'h18, 32'h55);
        chk(32'(perr), 32'h1);
        apb(1'b0, 8'h09, 32'h0);
        chk(32'(perr), 32'h1);
        rd_res(16'h3412);
        apb(1'b1, CSE_OFF_BYTEIN, 32'h63);
        rd_res(crc_upd(16'h3412, 8'h63));
    endtask : t_over
    // two blocks from a nonzero page; a status read must wait it out
    task automatic t_auto;
        logic [15:0] e;
        e = CSE_SEED_ONES;
        for (int i = 0; i < 512; i++)
            e = crc_upd(e, fdat(15'(PG * 256 + i)));
        apb(1'b1, CSE_OFF_CTRL, 32'h3);
        apb(1'b1, CSE_OFF_AUTO, 32'h80 | PG);
        apb(1'b1, CSE_OFF_CNT, 32'h2);
        apb(1'b0, CSE_OFF_AUTO, 32'h0);
        chk(rdata, 32'h80 | PG);
        apb(1'b0, CSE_OFF_CNT, 32'h0);
        chk(rdata, 32'h2);
        exp_fa = 15'(PG * 256);
        n_req = 0;
        apb(1'b1, CSE_OFF_CTRL, 32'h0);
        apb(1'b0, CSE_OFF_STAT, 32'h0);
        chk(32'(n_req), 32'd512);
        chk(32'(o_cpu_stall), 32'h0);
        apb(1'b1, CSE_OFF_AUTO, 32'h0);
        rd_res(e);
        chk(32'(n_req), 32'd512);
    endtask : t_auto
    task automatic tally_and_finish;
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        i_core_clk = 1'b0;
        i_rst_b = 1'b0;
        {i_psel, i_penable, i_pwrite, i_flash_valid, req_d} = '0;
        {i_paddr, i_flash_data, i_pwdata, addr_d, exp_fa} = '0;
        {err_count, n_checks, n_req, cyc} = '0;
        repeat (12) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        chk({29'h0, o_pready, o_cpu_stall, o_flash_req}, 32'h4);
        rd_res(16'h0);
        t_bytes;
        t_over;
        t_auto;
        tally_and_finish;
    end
endmodule : tb
`default_nettype wire
